/* include/asw_pkg.sv */
package asw_pkg;
    // Command codes
    localparam logic [7:0] CMD_WRITE_SECT    = 8'h30;
    localparam logic [7:0] CMD_WRITE_SECT_NR = 8'h31;
    localparam logic [7:0] CMD_WRITE_NOERASE = 8'h38;
    localparam logic [7:0] CMD_WRITE_VERIFY  = 8'h3c;
    localparam logic [7:0] CMD_WRITE_MULT_NE = 8'hcd;
    // Status bit positions
    localparam int ST_BUSY  = 7;
    localparam int ST_RDY   = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_SEEK  = 4;
    localparam int ST_DREQ  = 3;
    localparam int ST_CORR  = 2;
    localparam int ST_ERR   = 0;
    // Error bit positions
    localparam int ER_BBK  = 7;
    localparam int ER_UNC  = 6;
    localparam int ER_IDNF = 4;
    localparam int ER_ABRT = 2;
    localparam int ER_AMNF = 0;
    // Errors valid on the write family: bad block, id not found, abort, mark not found
    localparam logic [7:0] ERR_MASK_WRITE = 8'h95;
    localparam logic [7:0] ERR_MASK_BAD   = 8'h04;
    // Address mode bit in the drive/head register
    localparam int DH_LBA = 6;
    // Words per sector and a count of 256 sectors
    localparam logic [8:0] SECT_256   = 9'h100;
    localparam int         SECT_WORDS = 256;
    localparam logic [7:0] STATUS_RST = 8'h50;
    // Timing: busy before first data request
    localparam int BUSY_MIN_NS  = 8;
    localparam int CLK_NS       = 4;
    localparam int BUSY_CYCLES  = (BUSY_MIN_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [5:0] {
        ASW_IDLE  = 6'b000001,
        ASW_SETUP = 6'b000010,
        ASW_FILL  = 6'b000100,
        ASW_PROG  = 6'b001000,
        ASW_DONE  = 6'b010000,
        ASW_ABORT = 6'b100000
    } asw_state_e;
endpackage

/* verilog/asw_cmd_decode.sv */
`timescale 1ns/1ps
module asw_cmd_decode
    import asw_pkg::*;
(
    input  wire logic [7:0] cmd_in,
    output logic            is_write_out,
    output logic            is_verify_out
);
    always_comb begin
        unique case (cmd_in)
            CMD_WRITE_SECT, CMD_WRITE_SECT_NR: is_write_out = 1'b1;
            CMD_WRITE_NOERASE:                 is_write_out = 1'b1;
            CMD_WRITE_MULT_NE:                 is_write_out = 1'b1;
            CMD_WRITE_VERIFY:                  is_write_out = 1'b1;
            default:                           is_write_out = 1'b0;
        endcase
        is_verify_out = (cmd_in == CMD_WRITE_VERIFY);
    end
endmodule

/* verilog/asw_addr_step.sv */
`timescale 1ns/1ps
module asw_addr_step (
    input  wire logic        lba_mode_in,
    input  wire logic [7:0]  max_head_in,
    input  wire logic [7:0]  max_sect_in,
    input  wire logic [3:0]  head_in,
    input  wire logic [15:0] cyl_in,
    input  wire logic [7:0]  sect_in,
    output logic [3:0]       head_out,
    output logic [15:0]      cyl_out,
    output logic [7:0]       sect_out
);
    logic [27:0] lba_next;
    always_comb begin
        lba_next = {head_in, cyl_in, sect_in} + 28'h0000001;
        head_out = head_in;
        cyl_out  = cyl_in;
        sect_out = sect_in;
        if (lba_mode_in) begin
            {head_out, cyl_out, sect_out} = lba_next;
        end else if (sect_in < max_sect_in) begin
            sect_out = sect_in + 8'h01;
        end else begin
            sect_out = 8'h01;
            if ({4'h0, head_in} < max_head_in) begin
                head_out = head_in + 4'h1;
            end else begin
                head_out = 4'h0;
                cyl_out  = cyl_in + 16'h0001;
            end
        end
    end
endmodule

/* verilog/asw_write_ctrl.sv */
`timescale 1ns/1ps
module asw_write_ctrl
    import asw_pkg::*;
#(
    parameter int BUSY_CYC = BUSY_CYCLES
) (
    // Clock and reset
    input  wire logic        CLOCK_IN,
    input  wire logic        RSTN_IN,
    // Task file from host
    input  wire logic        CMD_WR_IN,
    input  wire logic [7:0]  CMD_IN,
    input  wire logic [7:0]  SECT_CNT_IN,
    input  wire logic [7:0]  SECT_NUM_IN,
    input  wire logic [15:0] CYL_IN,
    input  wire logic [7:0]  DRV_HEAD_IN,
    input  wire logic [7:0]  MAX_HEAD_IN,
    input  wire logic [7:0]  MAX_SECT_IN,
    // Transfer mode
    input  wire logic        DMA_EN_IN,
    input  wire logic        TRUE_IDE_IN,
    // Host data words
    input  wire logic        DATA_WR_IN,
    input  wire logic [15:0] DATA_IN,
    // Flash back end
    input  wire logic        MEDIA_DONE_IN,
    input  wire logic        MEDIA_FAIL_IN,
    input  wire logic [7:0]  MEDIA_ERR_IN,
    output logic             MEDIA_GO_OUT,
    output logic             MEDIA_VERIFY_OUT,
    output logic [27:0]      MEDIA_ADDR_OUT,
    output logic             BUF_WE_OUT,
    output logic [7:0]       BUF_IDX_OUT,
    output logic [15:0]      BUF_DATA_OUT,
    // Status to host
    output logic [7:0]       STATUS_OUT,
    output logic [7:0]       ERROR_OUT,
    output logic [7:0]       SECT_CNT_OUT,
    output logic [7:0]       SECT_NUM_OUT,
    output logic [15:0]      CYL_OUT,
    output logic [3:0]       HEAD_OUT,
    output logic             DMA_REQ_OUT,
    output logic             IRQ_OUT
);
    initial begin
        if (BUSY_CYC < 1 || BUSY_CYC > 256) $error("BUSY_CYC must be 1 to 256");
    end

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    asw_state_e  state_q;
    logic [8:0]  remain_q;
    logic [7:0]  word_q;
    logic [7:0]  busy_cnt_q;
    logic        verify_q;
    logic        lba_q;
    logic        dma_q;
    logic [7:0]  sect_q;
    logic [15:0] cyl_q;
    logic [3:0]  head_q;
    logic [7:0]  status_q;
    logic [7:0]  error_q;
    logic        irq_q;
    logic        go_q;
    logic        is_write;
    logic        is_verify;
    logic [7:0]  sect_d;
    logic [15:0] cyl_d;
    logic [3:0]  head_d;
    logic        last_word;

    // Reset is released through two flops so no flop leaves reset on a split edge
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    asw_cmd_decode u_dec (
        .cmd_in        (CMD_IN),
        .is_write_out  (is_write),
        .is_verify_out (is_verify)
    );

    asw_addr_step u_step (
        .lba_mode_in (lba_q),
        .max_head_in (MAX_HEAD_IN),
        .max_sect_in (MAX_SECT_IN),
        .head_in     (head_q),
        .cyl_in      (cyl_q),
        .sect_in     (sect_q),
        .head_out    (head_d),
        .cyl_out     (cyl_d),
        .sect_out    (sect_d)
    );

    assign last_word = DATA_WR_IN && (word_q == 8'(SECT_WORDS - 1));

    // Command sequencer
    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ASW_IDLE;
            busy_cnt_q <= 8'h00;
            go_q       <= 1'b0;
        end else begin
            go_q <= 1'b0;
            unique case (state_q)
                ASW_IDLE: begin
                    if (CMD_WR_IN) begin
                        busy_cnt_q <= 8'h00;
                        state_q    <= is_write ? ASW_SETUP : ASW_ABORT;
                    end
                end
                ASW_SETUP: begin
                    busy_cnt_q <= busy_cnt_q + 8'h01;
                    if (busy_cnt_q >= 8'(BUSY_CYC - 1)) begin
                        state_q <= ASW_FILL;
                    end
                end
                ASW_FILL: begin
                    if (last_word) begin
                        go_q    <= 1'b1;
                        state_q <= ASW_PROG;
                    end
                end
                ASW_PROG: begin
                    if (MEDIA_DONE_IN) begin
                        if (MEDIA_FAIL_IN || remain_q == 9'h001) begin
                            state_q <= ASW_DONE;
                        end else begin
                            state_q <= ASW_FILL;
                        end
                    end
                end
                ASW_DONE:  state_q <= ASW_IDLE;
                ASW_ABORT: state_q <= ASW_IDLE;
            endcase
        end
    end

    // Address, count and word tracking
    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            remain_q <= 9'h000;
            word_q   <= 8'h00;
            sect_q   <= 8'h00;
            cyl_q    <= 16'h0000;
            head_q   <= 4'h0;
            lba_q    <= 1'b0;
            verify_q <= 1'b0;
            dma_q    <= 1'b0;
        end else if (state_q == ASW_IDLE && CMD_WR_IN) begin
            remain_q <= (SECT_CNT_IN == 8'h00) ? SECT_256 : {1'b0, SECT_CNT_IN};
            sect_q   <= SECT_NUM_IN;
            cyl_q    <= CYL_IN;
            head_q   <= DRV_HEAD_IN[3:0];
            lba_q    <= DRV_HEAD_IN[DH_LBA];
            verify_q <= is_verify;
            dma_q    <= DMA_EN_IN && TRUE_IDE_IN;
            word_q   <= 8'h00;
        end else if (state_q == ASW_FILL && DATA_WR_IN) begin
            word_q <= word_q + 8'h01;
        end else if (state_q == ASW_PROG && MEDIA_DONE_IN && !MEDIA_FAIL_IN) begin
            remain_q <= remain_q - 9'h001;
            if (remain_q != 9'h001) begin
                sect_q <= sect_d;
                cyl_q  <= cyl_d;
                head_q <= head_d;
            end
        end
    end

    // Status, error and interrupt
    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STATUS_RST;
            error_q  <= 8'h00;
            irq_q    <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (state_q == ASW_IDLE && CMD_WR_IN) begin
                status_q[ST_BUSY] <= 1'b1;
                status_q[ST_DREQ] <= 1'b0;
                status_q[ST_ERR]  <= 1'b0;
                status_q[ST_CORR] <= 1'b0;
                error_q           <= 8'h00;
            end else if (state_q == ASW_SETUP && busy_cnt_q >= 8'(BUSY_CYC - 1)) begin
                status_q[ST_BUSY] <= 1'b0;
                status_q[ST_DREQ] <= 1'b1;
            end else if (state_q == ASW_FILL && last_word) begin
                status_q[ST_BUSY] <= 1'b1;
                status_q[ST_DREQ] <= 1'b0;
            end else if (state_q == ASW_PROG && MEDIA_DONE_IN) begin
                status_q[ST_BUSY] <= 1'b0;
                irq_q             <= 1'b1;
                if (MEDIA_FAIL_IN) begin
                    error_q          <= MEDIA_ERR_IN & ERR_MASK_WRITE;
                    status_q[ST_ERR] <= 1'b1;
                end else if (remain_q != 9'h001) begin
                    status_q[ST_DREQ] <= 1'b1;
                end
            end else if (state_q == ASW_ABORT) begin
                error_q           <= ERR_MASK_BAD;
                status_q[ST_ERR]  <= 1'b1;
                status_q[ST_BUSY] <= 1'b0;
                irq_q             <= 1'b1;
            end
        end
    end

    // Sector buffer fill path
    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            BUF_WE_OUT   <= 1'b0;
            BUF_IDX_OUT  <= 8'h00;
            BUF_DATA_OUT <= 16'h0000;
        end else begin
            BUF_WE_OUT   <= (state_q == ASW_FILL) && DATA_WR_IN;
            BUF_IDX_OUT  <= word_q;
            BUF_DATA_OUT <= DATA_IN;
        end
    end

    // Registered outputs
    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            DMA_REQ_OUT <= 1'b0;
        end else begin
            DMA_REQ_OUT <= dma_q && (state_q == ASW_FILL) && !last_word;
        end
    end

    assign STATUS_OUT       = status_q;
    assign ERROR_OUT        = error_q;
    assign IRQ_OUT          = irq_q;
    assign MEDIA_GO_OUT     = go_q;
    assign MEDIA_VERIFY_OUT = verify_q;
    assign MEDIA_ADDR_OUT   = {head_q, cyl_q, sect_q};
    assign SECT_CNT_OUT     = remain_q[7:0];
    assign SECT_NUM_OUT     = sect_q;
    assign CYL_OUT          = cyl_q;
    assign HEAD_OUT         = head_q;
endmodule

/* bench/asw_media_model.sv */
`timescale 1ns/1ps
module asw_media_model #(
    parameter int DLY = 6
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Program request and commanded outcome
    input  wire logic       go_in,
    input  wire logic       fail_req_in,
    input  wire logic [7:0] err_req_in,
    // Completion back to the block
    output logic            done_out,
    output logic            fail_out,
    output logic [7:0]      err_out
);
    int cnt_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= 0;
        end else if (go_in) begin
            cnt_q <= DLY;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    assign done_out = (cnt_q == 1);
    // Outcome lines carry garbage outside the done pulse, so stale values cannot pass
    assign fail_out = done_out ? fail_req_in : !fail_req_in;
    assign err_out  = done_out ? err_req_in : ~err_req_in;
endmodule

/* bench/asw_write_ctrl_props.sv */
`timescale 1ns/1ps
module asw_write_ctrl_props
    import asw_pkg::*;
#(
    parameter int BUSY_CYC = BUSY_CYCLES
) (
    input wire logic        CLOCK_IN,
    input wire logic        RSTN_IN,
    input wire logic        CMD_WR_IN,
    input wire logic [7:0]  CMD_IN,
    input wire logic        DATA_WR_IN,
    input wire logic [15:0] DATA_IN,
    input wire logic        MEDIA_DONE_IN,
    input wire logic        MEDIA_FAIL_IN,
    input wire logic        MEDIA_GO_OUT,
    input wire logic        BUF_WE_OUT,
    input wire logic [15:0] BUF_DATA_OUT,
    input wire logic [7:0]  STATUS_OUT,
    input wire logic [7:0]  ERROR_OUT,
    input wire logic        DMA_REQ_OUT,
    input wire logic        IRQ_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);
    wire idle = !STATUS_OUT[ST_BUSY] && !STATUS_OUT[ST_DREQ];
    wire wr   = CMD_IN inside {8'h30, 8'h31, 8'h38, 8'h3c, 8'hcd};
    wire acc  = CMD_WR_IN && idle && wr;
    wire bad  = CMD_WR_IN && idle && !wr;

    sequence s_first_drq;
        STATUS_OUT[ST_BUSY] ##(BUSY_CYC) (STATUS_OUT[ST_DREQ] && !STATUS_OUT[ST_BUSY]);
    endsequence

    chk_accept_busy: assert property (acc |=> s_first_drq)
        else $error("write accept handshake wrong");
    chk_first_noirq: assert property (acc |=> !IRQ_OUT [*3])
        else $error("interrupt before first fill");
    chk_word_buf: assert property (DATA_WR_IN && STATUS_OUT[ST_DREQ]
        |=> BUF_WE_OUT && BUF_DATA_OUT == $past(DATA_IN))
        else $error("data word not written to buffer");
    // The program strobe leaves on the same edge that drops the data request
    chk_fill_go: assert property ($fell(STATUS_OUT[ST_DREQ]) && STATUS_OUT[ST_BUSY]
        |-> MEDIA_GO_OUT)
        else $error("full buffer not programmed");
    chk_done_irq: assert property (MEDIA_DONE_IN |=> IRQ_OUT && !STATUS_OUT[ST_BUSY])
        else $error("sector end without interrupt");
    chk_fail_err: assert property (MEDIA_DONE_IN && MEDIA_FAIL_IN
        |=> STATUS_OUT[ST_ERR] && !STATUS_OUT[ST_DREQ])
        else $error("failed sector not terminated");
    chk_bad_abort: assert property (bad |-> ##2 IRQ_OUT && ERROR_OUT == ERR_MASK_BAD
        && STATUS_OUT[ST_ERR])
        else $error("bad code not aborted");
    chk_err_mask: assert property ((ERROR_OUT & ~ERR_MASK_WRITE) == 8'h00
        && !STATUS_OUT[ST_CORR])
        else $error("invalid error bit posted");
    chk_dma_window: assert property (DMA_REQ_OUT |-> STATUS_OUT[ST_DREQ])
        else $error("dma request outside transfer");
endmodule

bind asw_write_ctrl asw_write_ctrl_props #(.BUSY_CYC(BUSY_CYC)) u_props (
    .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .CMD_WR_IN(CMD_WR_IN), .CMD_IN(CMD_IN),
    .DATA_WR_IN(DATA_WR_IN), .DATA_IN(DATA_IN), .MEDIA_DONE_IN(MEDIA_DONE_IN),
    .MEDIA_FAIL_IN(MEDIA_FAIL_IN), .MEDIA_GO_OUT(MEDIA_GO_OUT), .BUF_WE_OUT(BUF_WE_OUT),
    .BUF_DATA_OUT(BUF_DATA_OUT), .STATUS_OUT(STATUS_OUT), .ERROR_OUT(ERROR_OUT),
    .DMA_REQ_OUT(DMA_REQ_OUT), .IRQ_OUT(IRQ_OUT));

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import asw_pkg::*;
    logic clk = 0, rstn = 0, cmd_wr = 0, dma_en = 0, tide = 0, dwr = 0, fail = 0;
    logic [7:0] cmd = 0, cnt = 0, sn = 0, dh = 0, merr_req = 0, merr, st, er, scnt, snum;
    logic [15:0] cyl = 0, din = 0, cyl_o;
    logic [27:0] maddr, go_addr;
    logic [3:0] hd;
    logic mdone, mfail, go, ver, go_ver, dreq, irq;
    int err_count = 0, n_compared = 0, irq_n = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (irq) irq_n++;
    always @(posedge clk) if (go) begin go_addr <= maddr; go_ver <= ver; end

    asw_write_ctrl #(.BUSY_CYC(2)) DUT (.CLOCK_IN(clk), .RSTN_IN(rstn), .CMD_WR_IN(cmd_wr),
        .CMD_IN(cmd), .SECT_CNT_IN(cnt), .SECT_NUM_IN(sn), .CYL_IN(cyl), .DRV_HEAD_IN(dh),
        .MAX_HEAD_IN(8'h0f), .MAX_SECT_IN(8'h3f), .DMA_EN_IN(dma_en), .TRUE_IDE_IN(tide),
        .DATA_WR_IN(dwr), .DATA_IN(din), .MEDIA_DONE_IN(mdone), .MEDIA_FAIL_IN(mfail),
        .MEDIA_ERR_IN(merr), .MEDIA_GO_OUT(go), .MEDIA_VERIFY_OUT(ver), .MEDIA_ADDR_OUT(maddr),
        .BUF_WE_OUT(), .BUF_IDX_OUT(), .BUF_DATA_OUT(), .STATUS_OUT(st), .ERROR_OUT(er),
        .SECT_CNT_OUT(scnt), .SECT_NUM_OUT(snum), .CYL_OUT(cyl_o), .HEAD_OUT(hd),
        .DMA_REQ_OUT(dreq), .IRQ_OUT(irq));
    asw_media_model u_media (.clk_in(clk), .rstn_in(rstn), .go_in(go), .fail_req_in(fail),
        .err_req_in(merr_req), .done_out(mdone), .fail_out(mfail), .err_out(merr));

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [27:0] e, input logic [27:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded polls sample at the falling edge, clear of the design's updates
    task automatic wait_st(input int b, input logic v);
        for (int i = 0; i <= 3000; i++) begin
            @(negedge clk);
            if (st[b] === v && !(v && st[ST_BUSY] !== 1'b0)) break;
            if (i == 3000) begin err_count++; test_done(); end
        end
        @(posedge clk);
    endtask

    task automatic wait_irq(input int n);
        for (int i = 0; i <= 3000; i++) begin
            @(negedge clk);
            if (irq_n >= n) break;
            if (i == 3000) begin err_count++; test_done(); end
        end
        @(posedge clk);
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("status reset", STATUS_RST, st);
    endtask

    task automatic issue(input logic [7:0] c, input logic [7:0] n, input logic [7:0] s);
        cmd_wr <= 1'b1;
        cmd <= c;
        cnt <= n;
        sn <= s;
        cyl <= 16'h1234;
        dh <= 8'h45;
        @(posedge clk);
        cmd_wr <= 1'b0;
    endtask

    // Host keeps data back until busy reads clear and the request is up
    task automatic fill(input logic [15:0] seed);
        wait_st(ST_DREQ, 1'b1);
        // The dma request follows the data request by one edge
        @(negedge clk);
        cmp("dma request", {27'h0, dma_en & tide}, {27'h0, dreq});
        @(posedge clk);
        for (int i = 0; i < SECT_WORDS; i++) begin
            dwr <= 1'b1;
            din <= seed + 16'(i);
            @(posedge clk);
        end
        dwr <= 1'b0;
    endtask

    task automatic test_codes;
        logic [7:0] codes [5] = '{8'h30, 8'h31, 8'h38, 8'h3c, 8'hcd};
        int n0;
        foreach (codes[k]) begin
            n0 = irq_n;
            dma_en <= 1'b1;
            tide <= k[0];
            issue(codes[k], 8'h02, 8'h10);
            fill(16'(k));
            cmp("irq first fill", n0, irq_n);
            wait_irq(n0 + 1);
            cmp("start addr", 28'h5123410, go_addr);
            cmp("verify flag", {27'h0, codes[k] == 8'h3c}, {27'h0, go_ver});
            fill(16'h100);
            wait_irq(n0 + 2);
            cmp("next addr", 28'h5123411, go_addr);
            cmp("status done", 8'h50, st & 8'hd9);
        end
        $display("test codes done");
    endtask

    task automatic test_count0;
        issue(CMD_WRITE_SECT, 8'h00, 8'h10);
        fill(16'h0);
        wait_irq(irq_n + 1);
        cmp("remaining", 8'hff, scnt);
        cmp("more data", 1'b1, st[ST_DREQ]);
        do_reset();
        $display("test count0 done");
    endtask

    task automatic test_error;
        merr_req <= 8'h50;
        issue(CMD_WRITE_VERIFY, 8'h03, 8'h20);
        fill(16'h0);
        wait_irq(irq_n + 1);
        fail <= 1'b1;
        fill(16'h0);
        wait_irq(irq_n + 1);
        fail <= 1'b0;
        cmp("err status", 8'h51, st & 8'hd9);
        cmp("err code", 8'h10, er);
        cmp("fail sect", 8'h21, snum);
        cmp("fail cyl", 16'h1234, cyl_o);
        cmp("remaining", 8'h02, scnt);
        $display("test error done");
    endtask

    task automatic test_bad;
        issue(8'h20, 8'h01, 8'h00);
        wait_irq(irq_n + 1);
        cmp("abort code", ERR_MASK_BAD, er);
        cmp("abort status", 8'h51, st & 8'hd9);
        $display("test bad done");
    endtask

    initial begin
        do_reset();
        test_codes();
        test_count0();
        test_error();
        test_bad();
        test_done();
    end
endmodule
